// file: nac_pkg.sv
// Purpose: Shared constants and types for the nonvolatile array access controller
// Assumes: 200 MHz system clock, register bus with one aligned word per register
// Notes: Register indices times four give the byte addresses
package nac_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned T_ATOMIC_NS = 3400000;
  localparam int unsigned T_SPLIT_NS = 1800000;
  localparam int unsigned NVM_BYTES = 4096;
  localparam int unsigned NVM_ADDR_W = 12;
  localparam int unsigned PROG_CNT_W = 24;
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned IRQ_W = 4;
  ////////////////////////////////////////////////////////////////////////
  localparam logic [IDX_W-1:0] IDX_CONTROL = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_DATA = 6'h20;
  localparam logic [IDX_W-1:0] IDX_ADDR_LO = 6'h21;
  localparam logic [IDX_W-1:0] IDX_ADDR_HI = 6'h22;
  localparam logic [IDX_W-1:0] IDX_SYSTEM = 6'h23;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h24;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h25;
  localparam int unsigned CTL_READ = 0;
  localparam int unsigned CTL_PROG = 1;
  localparam int unsigned CTL_ARM = 2;
  localparam int unsigned CTL_RIE = 3;
  localparam int unsigned CTL_MODE_LO = 4;
  localparam int unsigned CTL_MODE_HI = 5;
  localparam int unsigned SYS_GIE = 0;
  localparam int unsigned IRQ_PROG_DONE = 0;
  localparam int unsigned IRQ_READ_DONE = 1;
  localparam int unsigned IRQ_REFUSED = 2;
  localparam int unsigned IRQ_ARM_EXPIRED = 3;
  ////////////////////////////////////////////////////////////////////////
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] ARM_LAST = 3'h1;
  localparam logic [2:0] PROG_STALL = 3'h2;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [NVM_ADDR_W-1:0] ADDR_RESET = 12'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'h0,
    MODE_ERASE = 2'h1,
    MODE_WRITE = 2'h2,
    MODE_RSVD = 2'h3
  } nac_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_PROG = 2'h2
  } nac_state_t;
endpackage

// file: nac_nvm_array.sv
// Purpose: Byte array standing in for the nonvolatile cells
// Assumes: One commit pulse per finished programming operation
// Notes: Write-only mode can only clear bits, as real cells do
module nac_nvm_array
  import nac_pkg::*;
(
  input wire logic clk,
  input wire logic [NVM_ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic commit,
  input wire nac_mode_t commit_mode,
  input wire logic [NVM_ADDR_W-1:0] commit_addr,
  input wire logic [7:0] commit_data
);
  logic [7:0] mem [NVM_BYTES];
  logic [7:0] next_byte;

  ////////////////////////////////////////////////////////////////////////
  // Erase gives all ones
  always_comb begin
    case (commit_mode)
      MODE_ATOMIC: next_byte = commit_data;
      MODE_ERASE: next_byte = ERASED_BYTE;
      MODE_WRITE: next_byte = mem[commit_addr] & commit_data;
      default: next_byte = mem[commit_addr];
    endcase
  end

  always_ff @(posedge clk) begin
    if (commit) begin
      mem[commit_addr] <= next_byte;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule

// file: nac_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the byte-wide register file
// Assumes: Register file answers hit and read value combinationally
// Notes: Hold blocks new work while the processor is stalled
module nac_axil_slave
  import nac_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hold,
  input wire logic wr_hit,
  input wire logic rd_hit,
  input wire logic [7:0] rd_value,
  output logic reg_wr,
  output logic [IDX_W-1:0] reg_wr_idx,
  output logic [7:0] reg_wr_data,
  output logic reg_rd,
  output logic [IDX_W-1:0] reg_rd_idx
);
  logic aw_full, next_aw_full, w_full, next_w_full, w_lane0, next_w_lane0;
  logic [AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic next_bvalid, next_rvalid, do_wr, do_rd, wr_ok, rd_ok;

  ////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid && !hold;
  assign do_wr = aw_full && w_full && !s_axi_bvalid && !hold;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign wr_ok = wr_hit && (aw_addr[1:0] == 2'h0);
  assign rd_ok = rd_hit && (s_axi_araddr[1:0] == 2'h0);
  assign reg_wr_idx = aw_addr[IDX_W+1:2];
  assign reg_wr_data = w_byte;
  // A write with lane 0 disabled is answered but changes nothing
  assign reg_wr = do_wr && wr_ok && w_lane0;
  assign reg_rd_idx = s_axi_araddr[IDX_W+1:2];
  assign reg_rd = do_rd && rd_ok;

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_wr) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (do_rd) begin
      next_rvalid = 1'b1;
      next_rdata = rd_ok ? {24'h000000, rd_value} : 32'h00000000;
      next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (rst) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b0;
      next_rvalid = 1'b0;
      next_bresp = RESP_OKAY;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    aw_full <= next_aw_full;
    aw_addr <= next_aw_addr;
    w_full <= next_w_full;
    w_byte <= next_w_byte;
    w_lane0 <= next_w_lane0;
    s_axi_bvalid <= next_bvalid;
    s_axi_bresp <= next_bresp;
    s_axi_rvalid <= next_rvalid;
    s_axi_rdata <= next_rdata;
    s_axi_rresp <= next_rresp;
  end
endmodule

// file: nac_eeprom_ctrl.sv
// Purpose: Register-mapped access controller for a 4 Kbyte nonvolatile byte array
// Assumes: flash_selfprog_active comes from logic on the same clock
// Notes: A reset during programming lets the operation run to its end
// Operation
// - One byte selected by a 12-bit linear address over 4096 bytes.
// - Unused high address bits and top control bits read as zero.
// - Data register feeds writes and captures bytes fetched by reads.
// - Mode field: atomic 3.4 ms, erase 1.8 ms, write 1.8 ms, reserved.
// - Mode writes ignored while the programming strobe is set.
// - Reset clears the mode to atomic unless programming is under way.
// - Ready interrupt holds while enabled, globally enabled and not programming.
// - The arm bit clears itself four cycles after software sets it.
// - Programming starts only while armed; otherwise the strobe only sets the refused interrupt flag.
// - Strobe stays set during programming, cleared when the time has elapsed.
// - Starting programming stalls the processor for two cycles.
// - A read fetches the byte at once and stalls four cycles.
// - During programming reads are refused and the address is frozen.
// - No programming while flash self-programming is active.
//
// Local design decision: the AXI4-Lite interface to the registers.
module nac_eeprom_ctrl
  import nac_pkg::*;
#(
  parameter int unsigned PROG_ATOMIC_CYCLES = T_ATOMIC_NS / CLK_PERIOD_NS,
  parameter int unsigned PROG_SPLIT_CYCLES = T_SPLIT_NS / CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic flash_selfprog_active,
  output logic cpu_stall,
  output logic ready_irq,
  output logic irq
);
  nac_state_t state, next_state;
  nac_mode_t mode, next_mode, prog_mode, next_prog_mode;
  logic rie, next_rie, arm, next_arm, gie, next_gie;
  logic [2:0] arm_cnt, next_arm_cnt, stall_cnt, next_stall_cnt;
  logic [7:0] data, next_data, prog_data, next_prog_data, arr_byte, rd_value;
  logic [NVM_ADDR_W-1:0] addr, next_addr, prog_addr, next_prog_addr;
  logic [PROG_CNT_W-1:0] prog_cnt, next_prog_cnt;
  logic [IRQ_W-1:0] irq_status, next_irq_status, irq_mask, next_irq_mask, irq_set;
  logic reg_wr, reg_rd, wr_go, ctl_wr, busy, commit;
  logic start_req, start_ok, read_req, read_ok, stat_rd;
  logic [IDX_W-1:0] reg_wr_idx, reg_rd_idx;
  logic [7:0] wr_data;

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_CONTROL) && (idx <= IDX_IRQ_MASK);
  endfunction

  function automatic logic [PROG_CNT_W-1:0] prog_cycles(input nac_mode_t m);
    return (m == MODE_ATOMIC) ? PROG_CNT_W'(PROG_ATOMIC_CYCLES)
                              : PROG_CNT_W'(PROG_SPLIT_CYCLES);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  nac_axil_slave u_bus (
    .clk(clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .hold(cpu_stall),
    .wr_hit(is_mapped(reg_wr_idx)),
    .rd_hit(is_mapped(reg_rd_idx)),
    .rd_value(rd_value),
    .reg_wr(reg_wr),
    .reg_wr_idx(reg_wr_idx),
    .reg_wr_data(wr_data),
    .reg_rd(reg_rd),
    .reg_rd_idx(reg_rd_idx)
  );

  nac_nvm_array u_array (
    .clk(clk),
    .rd_addr(addr),
    .rd_data(arr_byte),
    .commit(commit),
    .commit_mode(prog_mode),
    .commit_addr(prog_addr),
    .commit_data(prog_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus writes are dropped in the reset cycle
  assign wr_go = reg_wr && !rst;
  assign ctl_wr = wr_go && (reg_wr_idx == IDX_CONTROL);
  assign busy = (state == ST_PROG);
  assign commit = busy && (prog_cnt == '0);
  assign start_req = ctl_wr && wr_data[CTL_PROG];
  assign start_ok = start_req && arm && !busy && !flash_selfprog_active
                    && (mode != MODE_RSVD);
  assign read_req = ctl_wr && wr_data[CTL_READ];
  assign read_ok = read_req && !busy && !start_req;
  assign stat_rd = reg_rd && (reg_rd_idx == IDX_IRQ_STATUS);
  assign cpu_stall = (stall_cnt != '0);
  assign ready_irq = rie && gie && !busy;
  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Unused bits read zero
  always_comb begin
    case (reg_rd_idx)
      IDX_CONTROL: rd_value = {2'h0, mode, rie, arm, busy, 1'b0};
      IDX_DATA: rd_value = data;
      IDX_ADDR_LO: rd_value = addr[7:0];
      IDX_ADDR_HI: rd_value = {4'h0, addr[NVM_ADDR_W-1:8]};
      IDX_SYSTEM: rd_value = {6'h00, flash_selfprog_active, gie};
      IDX_IRQ_STATUS: rd_value = {4'h0, irq_status};
      IDX_IRQ_MASK: rd_value = {4'h0, irq_mask};
      default: rd_value = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_prog_mode = prog_mode;
    next_rie = rie;
    next_arm = arm;
    next_arm_cnt = arm_cnt;
    next_gie = gie;
    next_data = data;
    next_prog_data = prog_data;
    next_addr = addr;
    next_prog_addr = prog_addr;
    next_prog_cnt = prog_cnt;
    next_stall_cnt = stall_cnt;
    next_irq_mask = irq_mask;
    irq_set = '0;
    if (arm) begin
      next_arm_cnt = arm_cnt - 3'h1;
      if (arm_cnt == ARM_LAST) begin
        next_arm = 1'b0;
        irq_set[IRQ_ARM_EXPIRED] = !start_ok;
      end
    end
    if (ctl_wr) begin
      next_rie = wr_data[CTL_RIE];
      if (!busy) begin
        next_mode = nac_mode_t'(wr_data[CTL_MODE_HI:CTL_MODE_LO]);
      end
      if (wr_data[CTL_ARM] && !start_ok) begin
        next_arm = 1'b1;
        next_arm_cnt = ARM_CYCLES;
        irq_set[IRQ_ARM_EXPIRED] = 1'b0;
      end
    end
    // The arm is spent by the strobe it enabled
    if (start_ok) begin
      next_arm = 1'b0;
      next_arm_cnt = '0;
    end
    if (start_req && !start_ok) begin
      irq_set[IRQ_REFUSED] = 1'b1;
    end
    if (read_req && !read_ok) begin
      irq_set[IRQ_REFUSED] = 1'b1;
    end
    if (wr_go && reg_wr_idx == IDX_DATA) begin
      next_data = wr_data;
    end
    if (wr_go && !busy && reg_wr_idx == IDX_ADDR_LO) begin
      next_addr[7:0] = wr_data;
    end
    if (wr_go && !busy && reg_wr_idx == IDX_ADDR_HI) begin
      next_addr[NVM_ADDR_W-1:8] = wr_data[NVM_ADDR_W-9:0];
    end
    if (wr_go && reg_wr_idx == IDX_SYSTEM) begin
      next_gie = wr_data[SYS_GIE];
    end
    if (wr_go && reg_wr_idx == IDX_IRQ_MASK) begin
      next_irq_mask = wr_data[IRQ_W-1:0];
    end
    if (read_ok) begin
      next_data = arr_byte;
      irq_set[IRQ_READ_DONE] = 1'b1;
    end
    if (stall_cnt != '0) begin
      next_stall_cnt = stall_cnt - 3'h1;
    end
    if (start_ok) begin
      next_stall_cnt = PROG_STALL;
    end else if (read_ok) begin
      next_stall_cnt = READ_STALL;
    end
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_PROG;
          next_prog_cnt = prog_cycles(mode) - PROG_CNT_W'(1);
          next_prog_mode = mode;
          next_prog_addr = addr;
          next_prog_data = data;
        end
      end
      ST_PROG: begin
        if (prog_cnt == '0) begin
          next_state = ST_IDLE;
          irq_set[IRQ_PROG_DONE] = 1'b1;
        end else begin
          next_prog_cnt = prog_cnt - PROG_CNT_W'(1);
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // A set in the clearing read's cycle survives
    next_irq_status = (stat_rd ? '0 : irq_status) | irq_set;
    // Reset keeps mode and address while busy
    if (rst) begin
      next_rie = 1'b0;
      next_arm = 1'b0;
      next_arm_cnt = '0;
      next_gie = 1'b0;
      next_data = DATA_RESET;
      next_stall_cnt = '0;
      next_irq_status = '0;
      next_irq_mask = '0;
      if (!busy) begin
        next_mode = MODE_ATOMIC;
        next_addr = ADDR_RESET;
        next_state = ST_IDLE;
        next_prog_cnt = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
    mode <= next_mode;
    prog_mode <= next_prog_mode;
    rie <= next_rie;
    arm <= next_arm;
    arm_cnt <= next_arm_cnt;
    gie <= next_gie;
    data <= next_data;
    prog_data <= next_prog_data;
    addr <= next_addr;
    prog_addr <= next_prog_addr;
    prog_cnt <= next_prog_cnt;
    stall_cnt <= next_stall_cnt;
    irq_status <= next_irq_status;
    irq_mask <= next_irq_mask;
  end

  ////////////////////////////////////////////////////////////////////////
  // Length of the current busy period, for checking only
  logic [PROG_CNT_W-1:0] busy_len;
  always_ff @(posedge clk) begin
    busy_len <= busy ? busy_len + PROG_CNT_W'(1) : '0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_hi_zero;
    reg_rd && reg_rd_idx == IDX_ADDR_HI |=> s_axi_rdata[31:4] == '0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("address high upper bits not zero");
  property p_read_fetch;
    read_ok |=> data == $past(arr_byte);
  endproperty
  a_read_fetch: assert property (p_read_fetch) else $error("read byte not captured");
  property p_prog_time;
    $fell(busy) |-> busy_len == prog_cycles(prog_mode);
  endproperty
  a_prog_time: assert property (p_prog_time) else $error("programming time wrong");
  property p_mode_lock;
    busy && ctl_wr |=> mode == $past(mode);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("mode changed while busy");
  property p_reset_mode;
    disable iff (1'b0) rst && !busy |=> mode == MODE_ATOMIC;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not cleared on reset");
  property p_ready;
    $fell(busy) && rie && gie |-> ready_irq && !$past(ready_irq);
  endproperty
  a_ready: assert property (p_ready) else $error("ready interrupt not raised");
  property p_arm_expire;
    $rose(arm) && !ctl_wr ##1 !ctl_wr [*3] |=> !arm;
  endproperty
  a_arm_expire: assert property (p_arm_expire) else $error("arm did not expire");
  property p_no_arm;
    start_req && !arm |=> busy == $past(busy);
  endproperty
  a_no_arm: assert property (p_no_arm) else $error("start without arm");
  property p_done;
    commit |=> !busy;
  endproperty
  a_done: assert property (p_done) else $error("strobe not cleared at end");
  property p_prog_stall;
    start_ok |=> cpu_stall [*2] ##1 !cpu_stall;
  endproperty
  a_prog_stall: assert property (p_prog_stall) else $error("program stall not two");
  property p_read_stall;
    read_ok |=> cpu_stall [*4] ##1 !cpu_stall;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read stall not four");
  property p_addr_frozen;
    busy |=> addr == $past(addr);
  endproperty
  a_addr_frozen: assert property (p_addr_frozen) else $error("address moved while busy");
  property p_flash_block;
    start_req && flash_selfprog_active && !busy |=> !busy;
  endproperty
  a_flash_block: assert property (p_flash_block) else $error("started during flash write");
  c_start: cover property (start_ok);
  c_read: cover property (read_ok);
  c_commit: cover property (commit);
  c_irq: cover property (irq);
endmodule

// file: nac_tb.sv
// Purpose: Self-checking bench for the nonvolatile array controller
// Assumes: Programming counts shortened to 40 and 20 cycles
// Notes: bready and rready stay high, so the bench never stalls answers
module testbench import nac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst = 1;
  logic awv = 0;
  logic wv = 0;
  logic arv = 0;
  logic fsa = 0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdv;
  logic awr, wr_r, bv, arr, rv, stall, rirq, irq;
  logic [1:0] br, rr, rsp;
  logic [31:0] rdw;
  int n_errors = 0;
  int checks_done = 0;
  int stall_n = 0;
  int busy_n = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  nac_eeprom_ctrl #(.PROG_ATOMIC_CYCLES(40), .PROG_SPLIT_CYCLES(20)) dut_u (
    .clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata({24'h000000, wd}), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdw),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .flash_selfprog_active(fsa), .cpu_stall(stall), .ready_irq(rirq), .irq(irq));
  initial forever #2.5 clk = ~clk;
  // With rie and gie set, ready interrupt is low only while busy, so it times programming
  always @(posedge clk) begin
    cyc++;
    if (stall === 1'b1) stall_n++;
    if (rirq === 1'b0) busy_n++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic ok;
    awa <= {idx, 2'b00};
    wd <= d;
    awv <= 1;
    wv <= 1;
    do begin
      @(posedge clk);
      ok = (!awv || awr === 1'b1) && (!wv || wr_r === 1'b1);
      if (awr === 1'b1) awv <= 0;
      if (wr_r === 1'b1) wv <= 0;
    end while (!ok);
    do @(posedge clk); while (bv !== 1'b1);
    rsp = br;
  endtask
  task automatic rd(input logic [5:0] idx);
    ara <= {idx, 2'b00};
    arv <= 1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk); while (rv !== 1'b1);
    rdv = rdw[7:0];
    rsp = rr;
  endtask
  task automatic prog(input logic [11:0] a, input logic [7:0] d, input logic [1:0] m);
    wr(IDX_ADDR_LO, a[7:0]); // Address loaded before access
    wr(IDX_ADDR_HI, {4'h0, a[11:8]});
    wr(IDX_DATA, d);
    wr(IDX_CONTROL, {2'b00, m, 4'hc});
    busy_n = 0;
    stall_n = 0;
    wr(IDX_CONTROL, {2'b00, m, 4'ha}); // Strobe straight after arm, nothing between
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      rd(IDX_CONTROL);
      k++;
    end while (rdv[CTL_PROG] === 1'b1 && k < 100);
  endtask
  task automatic rd_byte(input logic [11:0] a);
    wr(IDX_ADDR_LO, a[7:0]);
    wr(IDX_ADDR_HI, {4'h0, a[11:8]});
    stall_n = 0;
    wr(IDX_CONTROL, 8'h09);
    rd(IDX_DATA);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(IDX_CONTROL);
    chk("control", 8'h00, rdv); // Reset value
    rd(IDX_DATA);
    chk("data", DATA_RESET, rdv); // Reset value
    wr(IDX_ADDR_HI, 8'hff);
    chk("write resp", {6'h00, RESP_OKAY}, {6'h00, rsp});
    rd(IDX_ADDR_HI);
    chk("addr_high", 8'h0f, rdv); // Upper bits zero
    rd(6'h3f);
    chk("unmapped", {6'h00, RESP_SLVERR}, {6'h00, rsp});
    wr(6'h3f, 8'h00);
    chk("unmapped write", {6'h00, RESP_SLVERR}, {6'h00, rsp});
    $display("test reset done");
  endtask
  task automatic t_prog();
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_SYSTEM, 8'h01);
    wr(IDX_CONTROL, 8'h08);
    prog(12'h5a3, 8'h3c, MODE_ATOMIC);
    chk("ready_irq", 8'h00, {7'h0, rirq}); // Low while busy
    wr(IDX_CONTROL, 8'h18);
    chk("prog stall", 8'h02, stall_n[7:0]); // Two cycles
    wr(IDX_ADDR_LO, 8'h00);
    rd(IDX_CONTROL);
    chk("control busy", 8'h0a, rdv); // Mode kept, busy
    rd(IDX_ADDR_LO);
    chk("addr frozen", 8'ha3, rdv); // Address held
    wr(IDX_CONTROL, 8'h09);
    rd(IDX_IRQ_STATUS);
    chk("read refused", 8'h04, rdv & 8'h04); // Read refused
    wait_idle();
    chk("atomic time", 8'h28, busy_n[7:0]); // Atomic duration
    @(posedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    chk("ready_irq", 8'h01, {7'h0, rirq}); // High when idle
    rd(IDX_IRQ_STATUS);
    @(posedge clk);
    chk("status", 8'h01, rdv & 8'h01);
    chk("irq clear", 8'h00, {7'h0, irq});
    rd_byte(12'h5a3);
    chk("read byte", 8'h3c, rdv); // Byte fetched
    chk("read stall", 8'h04, stall_n[7:0]); // Four cycles
    $display("test program done");
  endtask
  task automatic t_modes();
    logic [1:0] m [3] = '{MODE_ERASE, MODE_WRITE, MODE_WRITE};
    logic [7:0] d [3] = '{8'h00, 8'h5a, 8'h0f};
    logic [7:0] e [3] = '{8'hff, 8'h5a, 8'h0a};
    for (int i = 0; i < 3; i++) begin
      prog(12'h5a3, d[i], m[i]);
      wait_idle();
      chk("split time", 8'h14, busy_n[7:0]); // Split duration
      rd_byte(12'h5a3);
      chk("mode result", e[i], rdv); // Erase gives ones, write clears bits
    end
    $display("test modes done");
  endtask
  task automatic t_guard();
    busy_n = 0;
    wr(IDX_CONTROL, 8'h0a);
    fsa <= 1;
    wr(IDX_CONTROL, 8'h0c);
    wr(IDX_CONTROL, 8'h0a);
    fsa <= 0;
    wr(IDX_CONTROL, 8'h0c);
    repeat (6) @(posedge clk);
    rd(IDX_CONTROL);
    chk("arm expired", 8'h00, rdv & 8'h04); // Arm self-clears
    wr(IDX_CONTROL, 8'h0a);
    wr(IDX_CONTROL, 8'h3c);
    wr(IDX_CONTROL, 8'h3a);
    chk("no start", 8'h00, busy_n[7:0]); // Refused starts
    rd_byte(12'h5a3);
    chk("unchanged", 8'h0a, rdv); // Array untouched
    $display("test guard done");
  endtask
  task automatic t_rst();
    prog(12'h123, 8'h77, MODE_ERASE);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    rd(IDX_CONTROL);
    chk("mode kept", 8'h12, rdv & 8'h32); // Busy keeps mode
    wait_idle();
    rd_byte(12'h123);
    chk("erase done", 8'hff, rdv); // Operation finishes
    $display("test reset busy done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_reset();
    t_prog();
    t_modes();
    t_guard();
    t_rst();
    complete_run();
  end
endmodule
